/* File: src/tsi_pkg.sv */
`default_nettype none

package tsi_pkg;

    // ************************************************************
    // widths
    // ************************************************************
    localparam int unsigned TSI_REG_W        = 16;
    localparam int unsigned TSI_ADDR_W       = 10;
    localparam int unsigned TSI_STAGES       = 12;

    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [9:0]  TSI_ADR_LOW_EN    = 10'h005;
    localparam logic [9:0]  TSI_ADR_HIGH_EN   = 10'h006;
    localparam logic [9:0]  TSI_ADR_DONE_EN   = 10'h007;
    localparam logic [9:0]  TSI_ADR_LOW_FLAGS = 10'h008;
    localparam logic [9:0]  TSI_ADR_HIGH_FLAGS = 10'h009;
    localparam logic [9:0]  TSI_ADR_DONE_FLAGS = 10'h00a;

    // ************************************************************
    // field positions inside the stage-done enable and flag words
    // ************************************************************
    localparam int unsigned TSI_GPIO_EN_BIT   = 12;
    localparam int unsigned TSI_GPIO_CFG_LSB  = 13;
    localparam int unsigned TSI_GPIO_CFG_MSB  = 14;
    localparam int unsigned TSI_GPIO_FLAG_BIT = 12;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [15:0] TSI_REG_RST       = 16'h0000;
    localparam logic        TSI_BIT_RST       = 1'b0;

    // input-event trigger condition
    typedef enum logic [1:0] {
        TSI_TRIG_LOW  = 2'b00,
        TSI_TRIG_RISE = 2'b01,
        TSI_TRIG_FALL = 2'b10,
        TSI_TRIG_HIGH = 2'b11
    } tsi_trig_t;

    // one access from the serial port's register side
    typedef struct packed {
        logic                  rd;
        logic                  wr;
        logic [TSI_ADDR_W-1:0] addr;
        logic [TSI_REG_W-1:0]  wdata;
    } tsi_req_t;

endpackage : tsi_pkg

`default_nettype wire

/* File: src/tsi_gpio_trig.sv */
`default_nettype none

module tsi_gpio_trig
    import tsi_pkg::*;
(
    input  wire logic      clk,
    input  wire logic      resetn,
    input  wire logic      pin_in,
    input  wire tsi_trig_t mode,
    output logic           level_hit,
    output logic           edge_hit
);

    logic sync1_r;
    logic sync1_nxt;
    logic sync2_r;
    logic sync2_nxt;
    logic prev_r;
    logic prev_nxt;

    // ************************************************************
    // pin synchroniser and history
    // ************************************************************
    // prev only ever looks at the second stage, never the first
    always_comb begin
        sync1_nxt = pin_in;
        sync2_nxt = sync1_r;
        prev_nxt  = sync2_r;
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sync1_r <= TSI_BIT_RST;
            sync2_r <= TSI_BIT_RST;
            prev_r  <= TSI_BIT_RST;
        end else begin
            sync1_r <= sync1_nxt;
            sync2_r <= sync2_nxt;
            prev_r  <= prev_nxt;
        end
    end

    // ************************************************************
    // trigger decode
    // ************************************************************
    // level modes hold while the pin sits at the level; edges last one cycle
    always_comb begin
        level_hit = 1'b0;
        edge_hit  = 1'b0;
        unique case (mode)
            TSI_TRIG_LOW:  level_hit = !sync2_r;
            TSI_TRIG_RISE: edge_hit  = sync2_r && !prev_r;
            TSI_TRIG_FALL: edge_hit  = !sync2_r && prev_r;
            TSI_TRIG_HIGH: level_hit = sync2_r;
        endcase
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_rise_edge;
        (mode == TSI_TRIG_RISE) && $rose(sync2_r) |-> edge_hit && !level_hit;
    endproperty
    a_rise_edge: assert property (p_rise_edge) else $error("rising edge missed");

    property p_edge_single;
        edge_hit && $stable(mode) |=> !edge_hit;
    endproperty
    a_edge_single: assert property (p_edge_single) else $error("edge longer than one cycle");

endmodule : tsi_gpio_trig

`default_nettype wire

/* File: src/tsi_irq.sv */
`default_nettype none

module tsi_irq
    import tsi_pkg::*;
#(
    parameter int unsigned NUM_STAGES = TSI_STAGES
)(
    input  wire logic                  clk,
    input  wire logic                  resetn,
    input  wire tsi_req_t              req,
    input  wire logic [NUM_STAGES-1:0] stage_done,
    input  wire logic [NUM_STAGES-1:0] thr_low_state,
    input  wire logic [NUM_STAGES-1:0] thr_high_state,
    input  wire logic                  gpio_pin_in,
    output logic [TSI_REG_W-1:0]       reg_rdata,
    output logic                       reg_rvalid,
    output logic                       irq_n_out,
    output logic                       irq_n_oe
);

    // ************************************************************
    // helpers
    // ************************************************************
    // stage words sit in the low bits; bits above read as zero
    function automatic logic [TSI_REG_W-1:0] stage_word(input logic [NUM_STAGES-1:0] v);
        return {{(TSI_REG_W-NUM_STAGES){1'b0}}, v};
    endfunction : stage_word

    function automatic logic rd_at(input tsi_req_t q, input logic [TSI_ADDR_W-1:0] a);
        return q.rd && (q.addr == a);
    endfunction : rd_at

    function automatic logic wr_at(input tsi_req_t q, input logic [TSI_ADDR_W-1:0] a);
        return q.wr && (q.addr == a);
    endfunction : wr_at

    // ************************************************************
    // state
    // ************************************************************
    logic [NUM_STAGES-1:0] low_en_r;
    logic [NUM_STAGES-1:0] low_en_nxt;
    logic [NUM_STAGES-1:0] high_en_r;
    logic [NUM_STAGES-1:0] high_en_nxt;
    logic [NUM_STAGES-1:0] done_en_r;
    logic [NUM_STAGES-1:0] done_en_nxt;
    logic                  gpio_en_r;
    logic                  gpio_en_nxt;
    tsi_trig_t             gpio_mode_r;
    tsi_trig_t             gpio_mode_nxt;
    logic [NUM_STAGES-1:0] done_flags_r;
    logic [NUM_STAGES-1:0] done_flags_nxt;
    logic                  gpio_flag_r;
    logic                  gpio_flag_nxt;
    logic [NUM_STAGES-1:0] low_prev_r;
    logic [NUM_STAGES-1:0] high_prev_r;
    logic                  thr_pend_r;
    logic                  thr_pend_nxt;
    logic                  seen_low_r;
    logic                  seen_low_nxt;
    logic                  seen_high_r;
    logic                  seen_high_nxt;
    logic                  irq_oe_r;
    logic                  irq_oe_nxt;
    logic                  irq_out_r;
    logic [TSI_REG_W-1:0]  rdata_r;
    logic [TSI_REG_W-1:0]  rdata_nxt;
    logic                  rvalid_r;

    logic                  rd_low;
    logic                  rd_high;
    logic                  rd_done;
    logic                  thr_ev;
    logic                  gpio_level;
    logic                  gpio_edge;
    logic                  gpio_edge_mode;
    logic [TSI_REG_W-1:0]  low_word;
    logic [TSI_REG_W-1:0]  high_word;

    // ************************************************************
    // input event trigger
    // ************************************************************
    tsi_gpio_trig u_gpio_trig (
        .clk       (clk),
        .resetn    (resetn),
        .pin_in    (gpio_pin_in),
        .mode      (gpio_mode_r),
        .level_hit (gpio_level),
        .edge_hit  (gpio_edge)
    );

    // ************************************************************
    // decode
    // ************************************************************
    // a read strobe marks the moment the read address is set up
    assign rd_low         = rd_at(req, TSI_ADR_LOW_FLAGS);
    assign rd_high        = rd_at(req, TSI_ADR_HIGH_FLAGS);
    assign rd_done        = rd_at(req, TSI_ADR_DONE_FLAGS);
    assign gpio_edge_mode = (gpio_mode_r == TSI_TRIG_RISE) || (gpio_mode_r == TSI_TRIG_FALL);
    assign low_word       = stage_word(thr_low_state);
    assign high_word      = stage_word(thr_high_state);
    // a flip of an enabled bit either way covers touch, change of set and release
    assign thr_ev = |((thr_low_state ^ low_prev_r) & low_en_r)
                  | |((thr_high_state ^ high_prev_r) & high_en_r);

    // ************************************************************
    // enable registers
    // ************************************************************
    always_comb begin
        low_en_nxt    = low_en_r;
        high_en_nxt   = high_en_r;
        done_en_nxt   = done_en_r;
        gpio_en_nxt   = gpio_en_r;
        gpio_mode_nxt = gpio_mode_r;
        if (wr_at(req, TSI_ADR_LOW_EN)) begin
            low_en_nxt = req.wdata[NUM_STAGES-1:0];
        end
        if (wr_at(req, TSI_ADR_HIGH_EN)) begin
            high_en_nxt = req.wdata[NUM_STAGES-1:0];
        end
        if (wr_at(req, TSI_ADR_DONE_EN)) begin
            done_en_nxt   = req.wdata[NUM_STAGES-1:0];
            gpio_en_nxt   = req.wdata[TSI_GPIO_EN_BIT];
            gpio_mode_nxt = tsi_trig_t'(req.wdata[TSI_GPIO_CFG_MSB:TSI_GPIO_CFG_LSB]);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            low_en_r    <= '0;
            high_en_r   <= '0;
            done_en_r   <= '0;
            gpio_en_r   <= TSI_BIT_RST;
            gpio_mode_r <= TSI_TRIG_LOW;
        end else begin
            low_en_r    <= low_en_nxt;
            high_en_r   <= high_en_nxt;
            done_en_r   <= done_en_nxt;
            gpio_en_r   <= gpio_en_nxt;
            gpio_mode_r <= gpio_mode_nxt;
        end
    end

    // ************************************************************
    // flags, threshold hold and pin drive
    // ************************************************************
    // a new event in the read cycle survives the clear, so nothing is lost
    always_comb begin
        done_flags_nxt = rd_done ? '0 : done_flags_r;
        done_flags_nxt = done_flags_nxt | (stage_done & done_en_r);
        // a level cause that still holds keeps its flag through the read
        gpio_flag_nxt  = rd_done ? (gpio_flag_r & gpio_level) : gpio_flag_r;
        gpio_flag_nxt  = gpio_flag_nxt | (gpio_en_r & (gpio_level | gpio_edge));

        seen_low_nxt  = seen_low_r | rd_low;
        seen_high_nxt = seen_high_r | rd_high;
        thr_pend_nxt  = thr_pend_r;
        if (thr_ev) begin
            thr_pend_nxt  = 1'b1;
            seen_low_nxt  = 1'b0;
            seen_high_nxt = 1'b0;
        end else if (seen_low_nxt && seen_high_nxt) begin
            thr_pend_nxt  = 1'b0;
            seen_low_nxt  = 1'b0;
            seen_high_nxt = 1'b0;
        end

        // edge modes give a one-cycle low pulse rather than a held level
        irq_oe_nxt = |(done_flags_nxt & done_en_nxt)
                   | thr_pend_nxt
                   | (gpio_en_nxt & !gpio_edge_mode & gpio_flag_nxt)
                   | (gpio_en_r & gpio_edge);
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            done_flags_r <= '0;
            gpio_flag_r  <= TSI_BIT_RST;
            low_prev_r   <= '0;
            high_prev_r  <= '0;
            thr_pend_r   <= TSI_BIT_RST;
            seen_low_r   <= TSI_BIT_RST;
            seen_high_r  <= TSI_BIT_RST;
            irq_oe_r     <= TSI_BIT_RST;
            irq_out_r    <= TSI_BIT_RST;
        end else begin
            done_flags_r <= done_flags_nxt;
            gpio_flag_r  <= gpio_flag_nxt;
            low_prev_r   <= thr_low_state;
            high_prev_r  <= thr_high_state;
            thr_pend_r   <= thr_pend_nxt;
            seen_low_r   <= seen_low_nxt;
            seen_high_r  <= seen_high_nxt;
            irq_oe_r     <= irq_oe_nxt;
            irq_out_r    <= 1'b0;
        end
    end

    // ************************************************************
    // read data
    // ************************************************************
    // the done flag word is captured before its clear takes effect
    always_comb begin
        rdata_nxt = rdata_r;
        if (req.rd) begin
            unique case (req.addr)
                TSI_ADR_LOW_EN:     rdata_nxt = stage_word(low_en_r);
                TSI_ADR_HIGH_EN:    rdata_nxt = stage_word(high_en_r);
                TSI_ADR_DONE_EN: begin
                    rdata_nxt = stage_word(done_en_r);
                    rdata_nxt[TSI_GPIO_EN_BIT] = gpio_en_r;
                    rdata_nxt[TSI_GPIO_CFG_MSB:TSI_GPIO_CFG_LSB] = gpio_mode_r;
                end
                TSI_ADR_LOW_FLAGS:  rdata_nxt = low_word;
                TSI_ADR_HIGH_FLAGS: rdata_nxt = high_word;
                TSI_ADR_DONE_FLAGS: begin
                    rdata_nxt = stage_word(done_flags_r);
                    rdata_nxt[TSI_GPIO_FLAG_BIT] = gpio_flag_r;
                end
                default:            rdata_nxt = TSI_REG_RST;
            endcase
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_r  <= TSI_REG_RST;
            rvalid_r <= TSI_BIT_RST;
        end else begin
            rdata_r  <= rdata_nxt;
            rvalid_r <= req.rd;
        end
    end

    assign reg_rdata  = rdata_r;
    assign reg_rvalid = rvalid_r;
    assign irq_n_out  = irq_out_r;
    assign irq_n_oe   = irq_oe_r;

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_pin_low_only;
        irq_n_out == 1'b0;
    endproperty
    a_pin_low_only: assert property (p_pin_low_only) else $error("pin driven high");

    property p_done_raise;
        |(stage_done & done_en_r) && !wr_at(req, TSI_ADR_DONE_EN) |=> irq_oe_r && |done_flags_r;
    endproperty
    a_done_raise: assert property (p_done_raise) else $error("done event did not pull pin");

    property p_done_en_write;
        wr_at(req, TSI_ADR_DONE_EN) |=> done_en_r == $past(req.wdata[NUM_STAGES-1:0]);
    endproperty
    a_done_en_write: assert property (p_done_en_write) else $error("done enable write lost");

    property p_done_clear;
        rd_done && !(|stage_done) |=> done_flags_r == '0;
    endproperty
    a_done_clear: assert property (p_done_clear) else $error("done flags not cleared");

    property p_read_release;
        rd_done && !thr_pend_r && !thr_ev && !(|stage_done) && !gpio_level && !gpio_edge
            |=> !irq_oe_r;
    endproperty
    a_read_release: assert property (p_read_release) else $error("pin not released on read");

    sequence s_thr_raised;
        thr_ev ##1 thr_pend_r;
    endsequence

    sequence s_no_thr_read;
        (!rd_low && !rd_high && !thr_ev) [*3];
    endsequence

    property p_thr_hold;
        s_thr_raised ##0 s_no_thr_read |-> irq_oe_r && thr_pend_r;
    endproperty
    a_thr_hold: assert property (p_thr_hold) else $error("threshold irq dropped unread");

    // the register port leaves one idle cycle between two reads
    property p_thr_both_read;
        thr_pend_r && !thr_ev ##1 rd_low && !thr_ev ##1 !thr_ev ##1 rd_high && !thr_ev
            |=> !thr_pend_r;
    endproperty
    a_thr_both_read: assert property (p_thr_both_read) else $error("threshold hold not freed");

    property p_thr_change;
        thr_ev |=> thr_pend_r && irq_oe_r;
    endproperty
    a_thr_change: assert property (p_thr_change) else $error("threshold change missed");

    property p_live_state;
        rd_low |=> reg_rvalid && reg_rdata == $past(low_word);
    endproperty
    a_live_state: assert property (p_live_state) else $error("low flags not live state");

    property p_gpio_flag;
        gpio_en_r && gpio_level |=> gpio_flag_r;
    endproperty
    a_gpio_flag: assert property (p_gpio_flag) else $error("input event flag not set");

    property p_enabled_flag_drives;
        |(done_flags_r & done_en_r) |-> irq_oe_r;
    endproperty
    a_enabled_flag_drives: assert property (p_enabled_flag_drives) else $error("flag idle pin");

endmodule : tsi_irq

`default_nettype wire

/* File: tb/tsi_host_model.sv */
`default_nettype none

// host side of the register port: strobes requests and watches the shared interrupt wire
module tsi_host_model
    import tsi_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic [TSI_REG_W-1:0] reg_rdata,
    input  wire logic                 reg_rvalid,
    input  wire logic                 irq_n_out,
    input  wire logic                 irq_n_oe,
    output var  tsi_req_t             req,
    output var  logic                 irq_pin
);
    timeunit 1ns;
    timeprecision 1ns;

    // ************************************************************
    // wire resolution
    // ************************************************************
    // the line has a board pull-up, so a released pin reads high
    assign irq_pin = irq_n_oe ? irq_n_out : 1'b1;

    initial begin
        req = '0;
    end

    // ************************************************************
    // register accesses
    // ************************************************************
    // an idle bus carries scrambled address and data so stale values never match by luck
    task automatic wr_reg(input logic [TSI_ADDR_W-1:0] a, input logic [TSI_REG_W-1:0] d);
        @(posedge clk);
        req <= {1'b0, 1'b1, a, d};
        @(posedge clk);
        req <= {1'b0, 1'b0, ~a, ~d};
    endtask : wr_reg

    // the answer is taken one cycle after the strobe, where valid stands
    task automatic rd_reg(input  logic [TSI_ADDR_W-1:0] a,
                          output logic [TSI_REG_W-1:0]  d,
                          output logic                  ok);
        @(posedge clk);
        req <= {1'b1, 1'b0, a, 16'h0000};
        @(posedge clk);
        req <= {1'b0, 1'b0, ~a, 16'hffff};
        #1;
        d  = reg_rdata;
        ok = reg_rvalid;
    endtask : rd_reg
endmodule : tsi_host_model

`default_nettype wire

/* File: tb/touch_sensor_interrupt_logic_test.sv */
`default_nettype none

`define CHK(what, exp, got) begin samples_checked++; if ((got) !== (exp)) begin n_fail++; \
    $display("BAD %s expected %h seen %h", what, (exp), (got)); end end

module touch_sensor_interrupt_logic_test
    import tsi_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic                  clk;
    logic                  resetn;
    tsi_req_t              req;
    logic [TSI_STAGES-1:0] stage_done;
    logic [TSI_STAGES-1:0] thr_low;
    logic [TSI_STAGES-1:0] thr_high;
    logic                  gpio_pin;
    logic [TSI_REG_W-1:0]  reg_rdata;
    logic                  reg_rvalid;
    logic                  irq_n_out;
    logic                  irq_n_oe;
    logic                  irq_pin;
    int                    n_fail;
    int                    samples_checked;
    int                    cycles;

    tsi_irq #(.NUM_STAGES(TSI_STAGES)) dut (
        .clk(clk), .resetn(resetn), .req(req), .stage_done(stage_done),
        .thr_low_state(thr_low), .thr_high_state(thr_high), .gpio_pin_in(gpio_pin),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe));

    tsi_host_model host (
        .clk(clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .irq_n_out(irq_n_out), .irq_n_oe(irq_n_oe), .req(req), .irq_pin(irq_pin));

    // ************************************************************
    // clock, watchdog and closing
    // ************************************************************
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_fail++;
            $display("BAD watchdog expected finish seen hang");
            close_out();
        end
    end

    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : close_out

    // ************************************************************
    // helpers
    // ************************************************************
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic rd_chk(input string what, input logic [9:0] a, input logic [15:0] exp);
        logic [15:0] d;
        logic        ok;
        host.rd_reg(a, d, ok);
        `CHK("read valid", 1'b1, ok)
        `CHK(what, exp, d)
    endtask : rd_chk

    task automatic pin_chk(input string what, input logic exp);
        `CHK(what, exp, irq_pin)
    endtask : pin_chk

    task automatic pulse_done(input logic [TSI_STAGES-1:0] m);
        @(posedge clk) stage_done <= m;
        @(posedge clk) stage_done <= '0;
        #1;
    endtask : pulse_done

    task automatic set_thr(input logic [TSI_STAGES-1:0] l, input logic [TSI_STAGES-1:0] h);
        @(posedge clk) begin
            thr_low  <= l;
            thr_high <= h;
        end
        tick(1);
    endtask : set_thr

    // ************************************************************
    // scenarios
    // ************************************************************
    task automatic t_regs();
        rd_chk("low en rst", TSI_ADR_LOW_EN, TSI_REG_RST);
        rd_chk("high en rst", TSI_ADR_HIGH_EN, TSI_REG_RST);
        rd_chk("done en rst", TSI_ADR_DONE_EN, TSI_REG_RST);
        rd_chk("done flags rst", TSI_ADR_DONE_FLAGS, TSI_REG_RST);
        host.wr_reg(TSI_ADR_LOW_EN, 16'hffff);
        host.wr_reg(TSI_ADR_HIGH_EN, 16'h0a5a);
        host.wr_reg(TSI_ADR_DONE_FLAGS, 16'hffff);
        rd_chk("low en", TSI_ADR_LOW_EN, 16'h0fff);
        rd_chk("high en", TSI_ADR_HIGH_EN, 16'h0a5a);
        rd_chk("flags read only", TSI_ADR_DONE_FLAGS, 16'h0000);
        rd_chk("unmapped", 10'h3ff, 16'h0000);
        pin_chk("pin idle", 1'b1);
        host.wr_reg(TSI_ADR_LOW_EN, 16'h0000);
        host.wr_reg(TSI_ADR_HIGH_EN, 16'h0000);
        $display("test regs finished");
    endtask : t_regs

    task automatic t_done();
        host.wr_reg(TSI_ADR_DONE_EN, 16'h0010);
        rd_chk("done en", TSI_ADR_DONE_EN, 16'h0010);
        pulse_done(12'h00f);
        pin_chk("masked stages", 1'b1);
        pulse_done(12'h010);
        pin_chk("done asserts", 1'b0);
        `CHK("drive level", 1'b0, irq_n_out)
        tick(3);
        pin_chk("done holds", 1'b0);
        rd_chk("done flags", TSI_ADR_DONE_FLAGS, 16'h0010);
        pin_chk("read releases", 1'b1);
        rd_chk("flags cleared", TSI_ADR_DONE_FLAGS, 16'h0000);
        pulse_done(12'h010);
        host.wr_reg(TSI_ADR_DONE_EN, 16'h0000);
        tick(1);
        pin_chk("disable releases", 1'b1);
        rd_chk("flag kept", TSI_ADR_DONE_FLAGS, 16'h0010);
        $display("test done source finished");
    endtask : t_done

    task automatic t_thr();
        host.wr_reg(TSI_ADR_LOW_EN, 16'h0201);
        set_thr(12'h040, 12'h000);
        pin_chk("masked change", 1'b1);
        set_thr(12'h041, 12'h000);
        pin_chk("first touch", 1'b0);
        tick(3);
        pin_chk("touch holds", 1'b0);
        rd_chk("low live", TSI_ADR_LOW_FLAGS, 16'h0041);
        pin_chk("one read only", 1'b0);
        rd_chk("high live", TSI_ADR_HIGH_FLAGS, 16'h0000);
        pin_chk("both read", 1'b1);
        set_thr(12'h241, 12'h000);
        pin_chk("set changed", 1'b0);
        rd_chk("high live 2", TSI_ADR_HIGH_FLAGS, 16'h0000);
        rd_chk("low live 2", TSI_ADR_LOW_FLAGS, 16'h0241);
        set_thr(12'h040, 12'h000);
        pin_chk("release", 1'b0);
        rd_chk("low live 3", TSI_ADR_LOW_FLAGS, 16'h0040);
        rd_chk("high live 3", TSI_ADR_HIGH_FLAGS, 16'h0000);
        pin_chk("freed", 1'b1);
        host.wr_reg(TSI_ADR_HIGH_EN, 16'h0800);
        set_thr(12'h000, 12'h800);
        pin_chk("high limit", 1'b0);
        rd_chk("high live 4", TSI_ADR_HIGH_FLAGS, 16'h0800);
        rd_chk("low live 4", TSI_ADR_LOW_FLAGS, 16'h0000);
        pin_chk("freed 2", 1'b1);
        host.wr_reg(TSI_ADR_HIGH_EN, 16'h0000);
        host.wr_reg(TSI_ADR_LOW_EN, 16'h0000);
        $display("test threshold source finished");
    endtask : t_thr

    // idle level is the one that does not trigger; edge modes pulse, level modes hold
    task automatic t_gpio(input tsi_trig_t m);
        logic idle_lvl;
        logic edge_mode;
        int   lows;
        idle_lvl  = (m == TSI_TRIG_LOW) || (m == TSI_TRIG_FALL);
        edge_mode = (m == TSI_TRIG_RISE) || (m == TSI_TRIG_FALL);
        lows      = 0;
        @(posedge clk) gpio_pin <= idle_lvl;
        tick(4);
        host.wr_reg(TSI_ADR_DONE_EN, {1'b0, m, 1'b1, 12'h000});
        rd_chk("input clean", TSI_ADR_DONE_FLAGS, 16'h0000);
        @(posedge clk) gpio_pin <= ~idle_lvl;
        for (int i = 0; i < 6; i++) begin
            tick(1);
            if (irq_pin === 1'b0) lows++;
        end
        `CHK("input low cycles", (edge_mode ? 1 : 4), lows)
        rd_chk("input flag", TSI_ADR_DONE_FLAGS, 16'h1000);
        pin_chk("input after read", edge_mode);
        @(posedge clk) gpio_pin <= idle_lvl;
        tick(4);
        rd_chk("input flag 2", TSI_ADR_DONE_FLAGS, edge_mode ? 16'h0000 : 16'h1000);
        pin_chk("input freed", 1'b1);
        host.wr_reg(TSI_ADR_DONE_EN, 16'h0000);
        $display("test input mode %0d finished", m);
    endtask : t_gpio

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        resetn          = 1'b0;
        stage_done      = '0;
        thr_low         = '0;
        thr_high        = '0;
        gpio_pin        = 1'b0;
        n_fail          = 0;
        samples_checked = 0;
        cycles          = 0;
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        t_regs();
        t_done();
        t_thr();
        t_gpio(TSI_TRIG_LOW);
        t_gpio(TSI_TRIG_RISE);
        t_gpio(TSI_TRIG_FALL);
        t_gpio(TSI_TRIG_HIGH);
        close_out();
    end
endmodule : touch_sensor_interrupt_logic_test

`default_nettype wire
